// *** hdl/usba_pkg.sv ***
// Purpose: Constants, types and register map for the shadow receive/transmit alias block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Register map and byte carrier shared by design and bench
package usba_pkg;
    localparam int          USBA_FIFO_DEPTH = 16;
    localparam int          USBA_PTR_W      = 4;
    localparam int          USBA_CNT_W      = 5;
    localparam logic [31:0] USBA_ALIAS_11   = 32'h5000105C;
    localparam logic [31:0] USBA_ALIAS_12   = 32'h50001060;
    localparam logic [31:0] USBA_CTRL_ADDR  = 32'h50001100;
    localparam logic [31:0] USBA_STAT_ADDR  = 32'h50001104;
    localparam logic [31:0] USBA_IRQ_ADDR   = 32'h50001108;
    localparam logic [31:0] USBA_MASK_ADDR  = 32'h5000110C;
    localparam int          USBA_CTRL_FIFO  = 0;
    localparam int          USBA_CTRL_IR    = 1;
    localparam int          USBA_ST_DR      = 0;
    localparam int          USBA_ST_TX_HOLDING_EMPTY    = 5;
    localparam int          USBA_IRQ_OVR    = 0;
    localparam int          USBA_IRQ_TXOVF  = 1;
    localparam int          USBA_IRQ_W      = 2;
    localparam logic [7:0]  USBA_BYTE_RST   = 8'h00;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } usba_byte_t;
endpackage : usba_pkg

// *** hdl/usba_fifo.sv ***
// Purpose: Byte FIFO used for receive and transmit paths
// Assumes: Push to a full FIFO is refused, contents untouched, unless a pop happens in the same cycle
// Notes:   Pop and push may occur in one cycle
`timescale 1ns/1ps
module usba_fifo
    import usba_pkg::*;
(
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_clear,
    input  wire logic                  i_push,
    input  wire logic [7:0]            i_data,
    input  wire logic                  i_pop,
    output logic      [7:0]            o_head,
    output logic                       o_full,
    output logic                       o_empty
);
    typedef struct packed {
        logic [USBA_PTR_W-1:0] wp;
        logic [USBA_PTR_W-1:0] rp;
        logic [USBA_CNT_W-1:0] cnt;
    } usba_fifo_st_t;

    usba_fifo_st_t st;
    usba_fifo_st_t next_st;
    logic [7:0]    mem [USBA_FIFO_DEPTH];
    logic          do_push;
    logic          do_pop;

    assign o_full  = (st.cnt == USBA_CNT_W'(USBA_FIFO_DEPTH));
    assign o_empty = (st.cnt == '0);
    assign o_head  = mem[st.rp];
    assign do_pop  = i_pop && !o_empty;
    assign do_push = i_push && (!o_full || do_pop);

    always_comb
    begin
        next_st = st;
        if (i_clear)
        begin
            next_st = '0;
        end
        else
        begin
            if (do_push)
                next_st.wp = st.wp + 1'b1;
            if (do_pop)
                next_st.rp = st.rp + 1'b1;
            if (do_push && !do_pop)
                next_st.cnt = st.cnt + 1'b1;
            else if (do_pop && !do_push)
                next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (do_push && !i_clear)
            mem[st.wp] <= i_data;
    end
endmodule : usba_fifo

// *** hdl/usba_top.sv ***
// Purpose: APB alias windows onto the receive buffer and transmit holding register
// Assumes: Serial framing lives outside; bytes arrive and leave as valid/ready pulses
// Notes:   One wait state per transfer; read data and error stand with pready
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module usba_top
    import usba_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [31:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire usba_byte_t  i_rx_line,
    input  wire usba_byte_t  i_rx_ir,
    input  wire logic        i_tx_ready,
    output usba_byte_t       o_tx_line,
    output usba_byte_t       o_tx_ir_n,
    output logic             o_irq
);
    typedef struct packed {
        logic [31:0]           prdata;
        logic                  pslverr;
        logic                  ack;
        logic                  fifo_en;
        logic                  ir_mode;
        logic [7:0]            rbuf;
        logic                  data_ready;
        logic [7:0]            thold;
        logic                  tx_holding_empty;
        logic [USBA_IRQ_W-1:0] irq_stat;
        logic [USBA_IRQ_W-1:0] irq_mask;
        usba_byte_t            tx_line;
        usba_byte_t            tx_ir_n;
    } usba_st_t;

    usba_st_t   st;
    usba_st_t   next_st;
    logic       req;
    logic       pre;
    logic       mapped;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       is_alias;
    logic       rd_alias;
    logic       wr_alias;
    usba_byte_t rx_in;
    logic       rx_full;
    logic       rx_empty;
    logic [7:0] rx_head;
    logic       tx_full;
    logic       tx_empty;
    logic [7:0] tx_head;
    logic       tx_take;
    logic       tx_busy;
    logic       fifo_clear;

    // Decode on the first access edge, complete on the second, so read data is registered yet ready with pready
    assign req        = i_psel && i_penable;
    assign pre        = req && !st.ack;
    assign acc        = req && st.ack;
    assign wr         = acc && i_pwrite;
    assign rd         = acc && !i_pwrite;
    assign is_alias   = (i_paddr == USBA_ALIAS_11) || (i_paddr == USBA_ALIAS_12);
    assign mapped     = is_alias || (i_paddr == USBA_CTRL_ADDR) || (i_paddr == USBA_STAT_ADDR)
                        || (i_paddr == USBA_IRQ_ADDR) || (i_paddr == USBA_MASK_ADDR);
    assign rd_alias   = rd && is_alias;
    assign wr_alias   = wr && is_alias;
    assign rx_in      = st.ir_mode ? i_rx_ir : i_rx_line;
    assign fifo_clear = wr && (i_paddr == USBA_CTRL_ADDR) && (i_pwdata[USBA_CTRL_FIFO] != st.fifo_en);
    assign tx_busy    = st.tx_line.valid || st.tx_ir_n.valid;
    assign tx_take    = st.fifo_en && !tx_empty && (!tx_busy || i_tx_ready);

    assign o_pready   = st.ack;
    assign o_prdata   = st.prdata;
    assign o_pslverr  = st.pslverr;
    assign o_tx_line  = st.tx_line;
    assign o_tx_ir_n  = st.tx_ir_n;
    assign o_irq      = |(st.irq_stat & st.irq_mask);

    usba_fifo u_rx_fifo (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_clear   (fifo_clear),
        .i_push    (st.fifo_en && rx_in.valid),
        .i_data    (rx_in.data),
        .i_pop     (st.fifo_en && rd_alias),
        .o_head    (rx_head),
        .o_full    (rx_full),
        .o_empty   (rx_empty)
    );

    usba_fifo u_tx_fifo (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_clear   (fifo_clear),
        .i_push    (st.fifo_en && wr_alias),
        .i_data    (i_pwdata[7:0]),
        .i_pop     (tx_take),
        .o_head    (tx_head),
        .o_full    (tx_full),
        .o_empty   (tx_empty)
    );

    always_comb
    begin
        logic [USBA_IRQ_W-1:0] ev;
        logic [7:0]            send;
        logic                  send_go;
        ev      = '0;
        send    = st.thold;
        send_go = 1'b0;
        next_st = st;
        next_st.pslverr = 1'b0;
        next_st.ack     = pre;
        // Error answer is prepared in the wait cycle so it stands with pready
        if (pre && !mapped)
            next_st.pslverr = 1'b1;

        // Receive path, FIFOs off, then FIFOs on
        if (!st.fifo_en)
        begin
            if (rd_alias)
                next_st.data_ready = 1'b0;
            if (rx_in.valid)
            begin
                if (st.data_ready && !rd_alias)
                    ev[USBA_IRQ_OVR] = 1'b1;
                next_st.rbuf       = rx_in.data;
                next_st.data_ready = 1'b1;
            end
        end
        else
        begin
            next_st.data_ready = !rx_empty;
            if (rx_in.valid && rx_full && !rd_alias)
                ev[USBA_IRQ_OVR] = 1'b1;
        end

        // Transmit path
        if (!st.fifo_en)
        begin
            if (st.tx_holding_empty == 1'b0 && (!tx_busy || i_tx_ready))
            begin
                send_go      = 1'b1;
                next_st.tx_holding_empty = 1'b1;
            end
            if (wr_alias)
            begin
                // write clears empty flag, overwrites pending byte
                next_st.thold = i_pwdata[7:0];
                next_st.tx_holding_empty  = 1'b0;
            end
        end
        else
        begin
            next_st.tx_holding_empty = tx_empty && !wr_alias;
            send         = tx_head;
            send_go      = tx_take;
            if (wr_alias && tx_full && !tx_take)
                ev[USBA_IRQ_TXOVF] = 1'b1;
        end

        // drive line or inverted infrared output
        if (i_tx_ready)
        begin
            next_st.tx_line.valid = 1'b0;
            next_st.tx_ir_n.valid = 1'b0;
        end
        if (send_go)
        begin
            if (st.ir_mode)
            begin
                next_st.tx_ir_n.data  = ~send;
                next_st.tx_ir_n.valid = 1'b1;
            end
            else
            begin
                next_st.tx_line.data  = send;
                next_st.tx_line.valid = 1'b1;
            end
        end

        // Register writes
        if (wr)
        begin
            if (i_paddr == USBA_CTRL_ADDR)
            begin
                next_st.fifo_en = i_pwdata[USBA_CTRL_FIFO];
                next_st.ir_mode = i_pwdata[USBA_CTRL_IR];
                if (fifo_clear)
                begin
                    next_st.data_ready = 1'b0;
                    next_st.tx_holding_empty       = 1'b1;
                end
            end
            else if (i_paddr == USBA_IRQ_ADDR)
                next_st.irq_stat = st.irq_stat & ~i_pwdata[USBA_IRQ_W-1:0];
            else if (i_paddr == USBA_MASK_ADDR)
                next_st.irq_mask = i_pwdata[USBA_IRQ_W-1:0];
        end
        // Set wins over clear
        next_st.irq_stat = next_st.irq_stat | ev;

        // Register reads, captured in the wait cycle
        if (pre && !i_pwrite)
        begin
            next_st.prdata = '0;
            if (is_alias)
            begin
                next_st.prdata[7:0] = st.fifo_en ? rx_head : st.rbuf;
            end
            else if (i_paddr == USBA_CTRL_ADDR)
            begin
                next_st.prdata[USBA_CTRL_FIFO] = st.fifo_en;
                next_st.prdata[USBA_CTRL_IR]   = st.ir_mode;
            end
            else if (i_paddr == USBA_STAT_ADDR)
            begin
                next_st.prdata[USBA_ST_DR]   = st.data_ready;
                next_st.prdata[USBA_ST_TX_HOLDING_EMPTY] = st.tx_holding_empty;
            end
            else if (i_paddr == USBA_IRQ_ADDR)
                next_st.prdata[USBA_IRQ_W-1:0] = st.irq_stat;
            else if (i_paddr == USBA_MASK_ADDR)
                next_st.prdata[USBA_IRQ_W-1:0] = st.irq_mask;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st      <= '0;
            st.tx_holding_empty <= 1'b1;
        end
        else
            st <= next_st;
    end
endmodule : usba_top

// *** test/usba_assertions.sv ***
// Purpose: Port checks for usba_top
// Assumes: One APB wait state; read data and error stand with pready
// Notes:   Bound to every usba_top
`timescale 1ns/1ps
module usba_chk
    import usba_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire usba_byte_t  i_rx_line,
    input wire usba_byte_t  i_rx_ir,
    input wire logic        i_tx_ready,
    input wire usba_byte_t  o_tx_line,
    input wire usba_byte_t  o_tx_ir_n,
    input wire logic        o_irq
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_acc;
        i_psel && i_penable;
    endsequence
    sequence s_alias;
        s_acc ##0 (i_paddr == USBA_ALIAS_11 || i_paddr == USBA_ALIAS_12);
    endsequence
    a_ready_wait: assert property (s_acc ##0 !o_pready |=> o_pready) else $error("no answer");
    a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("pready stuck");
    a_alias_ok: assert property (s_alias |=> !o_pslverr) else $error("alias errored");
    a_err_cause: assert property (o_pslverr |-> $past(i_psel && i_penable)) else $error("stray error");
    a_alias_upper: assert property (s_alias ##0 !i_pwrite |=> o_prdata[31:8] == 24'h000000)
        else $error("upper bits set");
    a_stat_layout: assert property (s_acc ##0 !i_pwrite && i_paddr == USBA_STAT_ADDR
        |=> (o_prdata & 32'hFFFFFFDE) == 32'h00000000) else $error("status bits");
    a_write_keeps: assert property (s_acc ##0 i_pwrite |=> $stable(o_prdata)) else $error("rdata moved");
    a_line_hold: assert property (o_tx_line.valid && !i_tx_ready
        |=> o_tx_line.valid && $stable(o_tx_line.data)) else $error("line byte lost");
    a_ir_hold: assert property (o_tx_ir_n.valid && !i_tx_ready
        |=> o_tx_ir_n.valid && $stable(o_tx_ir_n.data)) else $error("ir byte lost");
    a_one_path: assert property (!(o_tx_line.valid && o_tx_ir_n.valid)) else $error("both paths");
endmodule : usba_chk

bind usba_top usba_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_rx_line(i_rx_line), .i_rx_ir(i_rx_ir), .i_tx_ready(i_tx_ready),
    .o_tx_line(o_tx_line), .o_tx_ir_n(o_tx_ir_n), .o_irq(o_irq));

// *** test/usba_partner.sv ***
// Purpose: Remote serial transceiver seen as whole bytes
// Assumes: Framing happens outside the block
// Notes:   Stall holds off acceptance of transmit bytes
`timescale 1ns/1ps
module usba_partner
    import usba_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_stall,
    input  wire usba_byte_t i_tx_line,
    input  wire usba_byte_t i_tx_ir_n,
    output usba_byte_t      o_rx_line,
    output usba_byte_t      o_rx_ir,
    output logic            o_tx_ready
);
    logic [7:0] got[$];
    assign o_tx_ready = !i_stall && (i_tx_line.valid || i_tx_ir_n.valid);
    initial
    begin
        o_rx_line = '0;
        o_rx_ir = '0;
    end
    // Infrared bytes arrive inverted
    always @(posedge i_ref_clk)
        if (!i_rst_n)
            got.delete();
        else if (o_tx_ready)
            got.push_back(i_tx_line.valid ? i_tx_line.data : ~i_tx_ir_n.data);
    // Idle lines show the inverse of their previous data, so the sent line shows the inverse of its byte
    task automatic send(input logic ir, input logic [7:0] b);
        if (ir)
            o_rx_ir <= '{b, 1'b1};
        else
            o_rx_line <= '{b, 1'b1};
        @(posedge i_ref_clk);
        o_rx_line <= '{~o_rx_line.data, 1'b0};
        o_rx_ir <= '{~o_rx_ir.data, 1'b0};
        repeat (2) @(posedge i_ref_clk);
    endtask : send
endmodule : usba_partner

// *** test/tb.sv ***
// Purpose: Self-checking bench for usba_top
// Assumes: APB read data taken at the edge where pready is high
// Notes:   Partner models the remote transceiver
`timescale 1ns/1ps
module tb;
    import usba_pkg::*;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        psel = 0;
    logic        pen = 0;
    logic        pwr = 0;
    logic [31:0] addr = 0;
    logic [31:0] wdat = 0;
    logic [31:0] rdat;
    logic        rdy;
    logic        err;
    logic        irq;
    logic        stall = 0;
    logic        tx_rdy;
    usba_byte_t  rxl;
    usba_byte_t  rxi;
    usba_byte_t  txl;
    usba_byte_t  txi;
    logic [31:0] q;
    logic        qe;
    int          mismatches = 0;
    int          n_compared = 0;
    int          cyc = 0;
    always #10 clk = ~clk;
    usba_top uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(addr), .i_pwdata(wdat), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err), .i_rx_line(rxl),
        .i_rx_ir(rxi), .i_tx_ready(tx_rdy), .o_tx_line(txl), .o_tx_ir_n(txi), .o_irq(irq));
    usba_partner far (.i_ref_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_tx_line(txl),
        .i_tx_ir_n(txi), .o_rx_line(rxl), .o_rx_ir(rxi), .o_tx_ready(tx_rdy));
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (rdy !== 1'b1)
            @(posedge clk);
        q = rdat;
        qe = err;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
        apb(0, a, 32'h0);
        check(nm, q, e);
    endtask : rd
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            mismatches++;
            finish_test();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd(USBA_ALIAS_11, 32'h0, "alias rst");
        rd(USBA_STAT_ADDR, 32'h20, "status rst");
        far.send(0, 8'hA5);
        // byte read only once ready is seen
        rd(USBA_STAT_ADDR, 32'h21, "ready set");
        rd(USBA_ALIAS_12, 32'hA5, "rx byte");
        far.send(0, 8'h11);
        far.send(0, 8'h22);
        apb(1, USBA_MASK_ADDR, 32'h3);
        check("irq on", 32'(irq), 32'h1);
        rd(USBA_IRQ_ADDR, 32'h1, "overrun");
        rd(USBA_ALIAS_11, 32'h22, "newest");
        apb(1, USBA_IRQ_ADDR, 32'h1);
        check("irq off", 32'(irq), 32'h0);
        apb(0, 32'h50001200, 32'h0);
        check("slverr", 32'(qe), 32'h1);
        apb(1, USBA_CTRL_ADDR, 32'h2);
        far.send(1, 8'h3C);
        rd(USBA_ALIAS_12, 32'h3C, "ir rx");
        rd(USBA_STAT_ADDR, 32'h20, "tx_holding_empty before tx");
        apb(1, USBA_ALIAS_11, 32'hFFFFFF5A);
        repeat (4) @(posedge clk);
        check("ir tx", 32'(far.got[$]), 32'h5A);
        apb(1, USBA_CTRL_ADDR, 32'h0);
        stall <= 1;
        apb(1, USBA_ALIAS_11, 32'h01);
        apb(1, USBA_ALIAS_11, 32'h02);
        rd(USBA_STAT_ADDR, 32'h0, "empty clr");
        apb(1, USBA_ALIAS_12, 32'h03);
        stall <= 0;
        repeat (6) @(posedge clk);
        check("tx cnt", far.got.size(), 32'd3);
        check("tx last", 32'(far.got[$]), 32'h03);
        apb(1, USBA_CTRL_ADDR, 32'h1);
        for (int i = 0; i <= USBA_FIFO_DEPTH; i++)
            far.send(0, 8'(8'h40 + i));
        rd(USBA_IRQ_ADDR, 32'h1, "rx drop");
        for (int i = 0; i < USBA_FIFO_DEPTH; i++)
            rd(USBA_ALIAS_11, 32'h40 + i, "rx order");
        rd(USBA_STAT_ADDR, 32'h20, "rx empty");
        apb(1, USBA_IRQ_ADDR, 32'h1);
        stall <= 1;
        for (int i = 0; i <= USBA_FIFO_DEPTH + 1; i++)
            apb(1, USBA_ALIAS_12, 32'h80 + i);
        rd(USBA_IRQ_ADDR, 32'h2, "tx drop");
        stall <= 0;
        repeat (40) @(posedge clk);
        check("fifo cnt", far.got.size(), 32'd20);
        check("fifo last", 32'(far.got[$]), 32'h90);
        finish_test();
    end
endmodule : tb
